// *** core/fec_pkg.sv ***
// package for the flash erase command controller (host side)
// assumes a parallel nor flash with write-strobe command bus
package fec_pkg;
   localparam int unsigned ADDR_W        = 12;
   localparam int unsigned DATA_W        = 8;
   localparam int unsigned CLK_MHZ       = 10;
   localparam int unsigned CLK_NS        = 100;
   // unlock addresses and data codes, byte mode
   localparam logic [11:0] UNLOCK_A1     = 12'haaa;
   localparam logic [11:0] UNLOCK_A2     = 12'h555;
   localparam logic [7:0]  UNLOCK_D1     = 8'haa;
   localparam logic [7:0]  UNLOCK_D2     = 8'h55;
   localparam logic [7:0]  CMD_SETUP     = 8'h80;
   localparam logic [7:0]  CMD_CHIP      = 8'h10;
   localparam logic [7:0]  CMD_SECTOR    = 8'h30;
   localparam logic [7:0]  CMD_SUSPEND   = 8'hb0;
   localparam logic [7:0]  CMD_RESUME    = 8'h30;
   localparam logic [7:0]  CMD_RESET     = 8'hf0;
   // status bit positions
   localparam int unsigned POLL_BIT      = 7;
   localparam int unsigned TOGGLE_BIT    = 6;
   localparam int unsigned TIMER_BIT     = 3;
   localparam int unsigned SUSP_TGL_BIT  = 2;
   // timing
   localparam int unsigned LOAD_TOUT_US  = 50;
   localparam int unsigned SUSPEND_US    = 20;
   localparam int unsigned WE_LOW_NS     = 200;
   localparam int unsigned WE_HIGH_NS    = 200;
   localparam int unsigned WE_LOW_CYC    = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned WE_HIGH_CYC   = (WE_HIGH_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned SUSPEND_CYC   = SUSPEND_US * CLK_MHZ;
   localparam int unsigned LOAD_TOUT_CYC = LOAD_TOUT_US * CLK_MHZ;
   // commands from the user port
   localparam logic [2:0]  OP_CHIP       = 3'h0;
   localparam logic [2:0]  OP_SECTOR     = 3'h1;
   localparam logic [2:0]  OP_ADD_SECTOR = 3'h2;
   localparam logic [2:0]  OP_SUSPEND    = 3'h3;
   localparam logic [2:0]  OP_RESUME     = 3'h4;
   localparam logic [2:0]  OP_RESET      = 3'h5;
   localparam int unsigned SEQ_LEN       = 6;
endpackage : fec_pkg

// *** core/fec_wr_if.sv ***
// write-cycle request carrier between sequencer and strobe engine
// assumes one clock shared by both modules
`timescale 1ns/1ps
interface fec_wr_if;
   import fec_pkg::*;
   logic              req;
   logic              done;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] data;
   modport seq (output req, output addr, output data, input done);
   modport eng (input req, input addr, input data, output done);
endinterface : fec_wr_if

// *** core/fec_wr_engine.sv ***
// one asynchronous flash write cycle per request
// assumes ce is held low by the top while writing
`timescale 1ns/1ps
module fec_wr_engine
   import fec_pkg::*;
(
   input  wire logic         clk_in,     // clock
   input  wire logic         rst_in,     // async reset
   fec_wr_if.eng             wr,         // request side
   output logic              we_n_out,   // write strobe
   output logic [ADDR_W-1:0] addr_out,   // address pins
   output logic [DATA_W-1:0] dq_o_out,   // data drive
   output logic              dq_oe_out   // data enable
);
   typedef enum logic [2:0] {
      FEW_IDLE = 3'b001,
      FEW_LOW  = 3'b010,
      FEW_HIGH = 3'b100
   } fec_we_e;
   fec_we_e    st_q;
   logic [3:0] cnt_q;
   wire        cnt_end = (cnt_q == 4'h0);
   assign wr.done = (st_q == FEW_HIGH) && cnt_end;
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         st_q      <= FEW_IDLE;
         cnt_q     <= 4'h0;
         we_n_out  <= 1'b1;
         addr_out  <= '0;
         dq_o_out  <= '0;
         dq_oe_out <= 1'b0;
      end else begin
         case (st_q)
            FEW_IDLE: if (wr.req) begin
               st_q      <= FEW_LOW;
               cnt_q     <= 4'(WE_LOW_CYC - 1);
               addr_out  <= wr.addr;
               dq_o_out  <= wr.data;
               dq_oe_out <= 1'b1;
               we_n_out  <= 1'b0;
            end
            FEW_LOW: if (cnt_end) begin
               st_q     <= FEW_HIGH;
               cnt_q    <= 4'(WE_HIGH_CYC - 1);
               we_n_out <= 1'b1;
            end else cnt_q <= cnt_q - 4'h1;
            FEW_HIGH: if (cnt_end) begin
               st_q      <= FEW_IDLE;
               dq_oe_out <= 1'b0;
            end else cnt_q <= cnt_q - 4'h1;
            default: st_q <= FEW_IDLE;
         endcase
      end
   end
endmodule : fec_wr_engine

// *** core/fec_ctrl.sv ***
// host-side erase command controller for a parallel nor flash
// assumes device pins wired directly; ready_busy_n from the pin
`timescale 1ns/1ps
module fec_ctrl
   import fec_pkg::*;
#(
   parameter int unsigned TOUT_CYC = LOAD_TOUT_CYC,
   parameter int unsigned SUSP_CYC = SUSPEND_CYC
)(
   input  wire logic              clk_in,       // clock
   input  wire logic              rst_in,       // async reset
   input  wire logic              cmd_valid_in, // command strobe
   input  wire logic [2:0]        cmd_op_in,    // command code
   input  wire logic [ADDR_W-1:0] cmd_sector_in,// sector address
   input  wire logic              hw_reset_in,  // request pin reset
   output logic                   cmd_ready_out,// may take command
   output logic                   busy_out,     // erase in progress
   output logic                   suspended_out,// erase suspended
   output logic                   loading_out,  // load window open
   output logic                   done_out,     // erase finished
   output logic                   we_n_out,     // flash write strobe
   output logic                   ce_n_out,     // flash chip enable
   output logic                   oe_n_out,     // flash output enable
   output logic                   reset_n_out,  // flash reset pin
   output logic [ADDR_W-1:0]      addr_out,     // flash address
   output logic [DATA_W-1:0]      dq_o_out,     // flash data out
   output logic                   dq_oe_out,    // flash data drive
   input  wire logic [DATA_W-1:0] dq_i_in,      // flash data in
   input  wire logic              ready_busy_n  // flash ready pin
);
   import fec_pkg::*;
   typedef enum logic [6:0] {
      FEC_IDLE = 7'b0000001,
      FEC_SEQ  = 7'b0000010,
      FEC_CHIP = 7'b0000100,
      FEC_LOAD = 7'b0001000,
      FEC_ERAS = 7'b0010000,
      FEC_SWT  = 7'b0100000,
      FEC_SUSP = 7'b1000000
   } fec_st_e;
   // ------------------------------------------------------------
   // pin synchronisers: ready pin and poll bit
   // ------------------------------------------------------------
   wire  [1:0] pin_raw = {dq_i_in[POLL_BIT], ready_busy_n};
   logic [1:0] pin_flt;
   for (genvar g = 0; g < 2; g++) begin : g_sync
      logic [2:0] sh_q;
      logic       flt_q;
      always_ff @(posedge clk_in or posedge rst_in) begin
         if (rst_in) sh_q <= 3'b111;
         else sh_q <= {sh_q[1:0], pin_raw[g]};
      end
      // a change counts once the last two stages agree
      always_ff @(posedge clk_in or posedge rst_in) begin
         if (rst_in) flt_q <= 1'b1;
         else if (sh_q[2] == sh_q[1]) flt_q <= sh_q[2];
      end
      assign pin_flt[g] = flt_q;
   end
   wire ready_sync = pin_flt[0];
   wire poll_sync  = pin_flt[1];
   // ------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------
   fec_wr_if wr ();
   fec_st_e            st_q;
   logic [2:0]         idx_q;
   logic [2:0]         len_q;
   logic               chip_q;
   logic [ADDR_W-1:0]  sec_q;
   logic               req_q;
   logic [15:0]        tmr_q;
   logic               rst_pin_q;
   logic               done_q;
   logic               wip_q;
   wire idle_w = !req_q && !wip_q;
   wire take = cmd_valid_in && cmd_ready_out;
   wire op_chip = take && (cmd_op_in == OP_CHIP);
   wire op_sect = take && (cmd_op_in == OP_SECTOR);
   wire op_add  = take && (cmd_op_in == OP_ADD_SECTOR);
   wire op_susp = take && (cmd_op_in == OP_SUSPEND);
   wire op_res  = take && (cmd_op_in == OP_RESUME);
   wire op_rst  = take && (cmd_op_in == OP_RESET);
   wire tmr_end = (tmr_q == 16'h0);
   // one write of the six-step unlock sequence, by index
   logic [ADDR_W-1:0] seq_a;
   logic [DATA_W-1:0] seq_d;
   always_comb begin
      seq_a = UNLOCK_A1;
      seq_d = UNLOCK_D1;
      case (idx_q)
         3'h0: begin seq_a = UNLOCK_A1; seq_d = UNLOCK_D1; end
         3'h1: begin seq_a = UNLOCK_A2; seq_d = UNLOCK_D2; end
         3'h2: begin seq_a = UNLOCK_A1; seq_d = CMD_SETUP; end
         3'h3: begin seq_a = UNLOCK_A1; seq_d = UNLOCK_D1; end
         3'h4: begin seq_a = UNLOCK_A2; seq_d = UNLOCK_D2; end
         default: begin
            seq_a = chip_q ? UNLOCK_A1 : sec_q;
            seq_d = chip_q ? CMD_CHIP : CMD_SECTOR;
         end
      endcase
   end
   // single-write commands use len 1, idx 5 keeps final cycle form
   logic [DATA_W-1:0] one_d_q;
   assign wr.req  = req_q;
   assign wr.addr = (len_q == 3'h1) ? sec_q : seq_a;
   assign wr.data = (len_q == 3'h1) ? one_d_q : seq_d;
   assign cmd_ready_out = idle_w && !rst_pin_q && (st_q != FEC_SWT)
                          && (st_q != FEC_SEQ);
   assign busy_out      = (st_q != FEC_IDLE);
   assign suspended_out = (st_q == FEC_SUSP);
   assign loading_out   = (st_q == FEC_LOAD);
   assign done_out      = done_q;
   assign ce_n_out      = 1'b0;
   assign oe_n_out      = 1'b1;
   assign reset_n_out   = !rst_pin_q;
   // write in flight from hand-over until done; gates new commands
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) wip_q <= 1'b0;
      else if (req_q) wip_q <= 1'b1;
      else if (wr.done) wip_q <= 1'b0;
   end
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         st_q <= FEC_IDLE;
         idx_q <= 3'h0; len_q <= 3'h0; chip_q <= 1'b0;
         sec_q <= '0; one_d_q <= '0; req_q <= 1'b0;
         tmr_q <= 16'h0; rst_pin_q <= 1'b0; done_q <= 1'b0;
      end else begin
         done_q <= 1'b0;
         if (req_q) req_q <= 1'b0;
         if (!tmr_end) tmr_q <= tmr_q - 16'h1;
         if (hw_reset_in && !rst_pin_q) begin
            rst_pin_q <= 1'b1;
            st_q      <= FEC_IDLE;
            tmr_q     <= 16'(WE_LOW_CYC * 5);
         end else if (rst_pin_q) begin
            if (tmr_end) rst_pin_q <= 1'b0;
         end else begin
            case (st_q)
               FEC_IDLE: if (op_chip || op_sect) begin
                  st_q <= FEC_SEQ;
                  chip_q <= op_chip; sec_q <= cmd_sector_in;
                  idx_q <= 3'h0; len_q <= 3'(SEQ_LEN); req_q <= 1'b1;
               end
               FEC_SEQ: if (wr.done) begin
                  if (idx_q == 3'h5) begin
                     st_q  <= chip_q ? FEC_CHIP : FEC_LOAD;
                     tmr_q <= 16'(TOUT_CYC);
                  end else begin
                     idx_q <= idx_q + 3'h1;
                     req_q <= 1'b1;
                  end
               end
               FEC_CHIP: if (tmr_end && ready_sync) begin
                  st_q <= FEC_IDLE; done_q <= 1'b1;
               end
               FEC_LOAD: begin
                  if (op_add) begin
                     sec_q <= cmd_sector_in; len_q <= 3'h1;
                     one_d_q <= CMD_SECTOR; req_q <= 1'b1;
                     tmr_q <= 16'(TOUT_CYC);
                  end else if (op_susp) begin
                     len_q <= 3'h1; one_d_q <= CMD_SUSPEND;
                     req_q <= 1'b1; st_q <= FEC_SUSP;
                  end else if (op_rst) begin
                     len_q <= 3'h1; one_d_q <= CMD_RESET;
                     req_q <= 1'b1; st_q <= FEC_IDLE;
                  end else if (tmr_end && idle_w) begin
                     st_q <= FEC_ERAS;
                  end
               end
               FEC_ERAS: begin
                  if (op_susp) begin
                     len_q <= 3'h1; one_d_q <= CMD_SUSPEND;
                     req_q <= 1'b1; st_q <= FEC_SWT;
                     tmr_q <= 16'(SUSP_CYC);
                  end else if (ready_sync && idle_w && tmr_end) begin
                     st_q <= FEC_IDLE; done_q <= 1'b1;
                  end
               end
               FEC_SWT: if (idle_w && (tmr_end || poll_sync)) begin
                  st_q <= FEC_SUSP;
               end
               FEC_SUSP: if (op_res) begin
                  len_q <= 3'h1; one_d_q <= CMD_RESUME;
                  req_q <= 1'b1; st_q <= FEC_ERAS;
                  tmr_q <= 16'(SUSP_CYC); // busy pin settle guard
               end
               default: st_q <= FEC_IDLE;
            endcase
         end
      end
   end
   // ------------------------------------------------------------
   // strobe engine
   // ------------------------------------------------------------
   fec_wr_engine u_eng (
      .clk_in    (clk_in),
      .rst_in    (rst_in),
      .wr        (wr),
      .we_n_out  (we_n_out),
      .addr_out  (addr_out),
      .dq_o_out  (dq_o_out),
      .dq_oe_out (dq_oe_out)
   );
endmodule : fec_ctrl

// *** tb/fec_ctrl_chk.sv ***
// assertions on the erase controller top ports
// assumes one clock, reset active high
`timescale 1ns/1ps
module fec_ctrl_chk
   import fec_pkg::*;
#(
   parameter int unsigned TOUT_CYC = LOAD_TOUT_CYC,
   parameter int unsigned SUSP_CYC = SUSPEND_CYC
)(
   input wire logic              clk_in,        // clock
   input wire logic              rst_in,        // reset
   input wire logic              cmd_valid_in,  // command strobe
   input wire logic [2:0]        cmd_op_in,     // command code
   input wire logic              hw_reset_in,   // pin reset request
   input wire logic              cmd_ready_out, // may take command
   input wire logic              busy_out,      // erase running
   input wire logic              suspended_out, // suspended
   input wire logic              done_out,      // erase finished
   input wire logic              we_n_out,      // write strobe
   input wire logic              ce_n_out,      // chip enable
   input wire logic              oe_n_out,      // output enable
   input wire logic              reset_n_out,   // flash reset pin
   input wire logic [ADDR_W-1:0] addr_out,      // flash address
   input wire logic [DATA_W-1:0] dq_o_out,      // flash data
   input wire logic              dq_oe_out,     // data drive
   input wire logic              ready_busy_n   // flash ready pin
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   // ---------------------------------------------
   // strobe and pin relations
   // ---------------------------------------------
   a_chip_first_write: assert property (cmd_valid_in && cmd_ready_out &&
      cmd_op_in == OP_CHIP && !busy_out |=> ##1 !we_n_out &&
      addr_out == UNLOCK_A1 && dq_o_out == UNLOCK_D1) else $error("bad first");
   a_strobe_width: assert property ($fell(we_n_out) |=>
      !we_n_out ##1 we_n_out) else $error("strobe width");
   a_addr_hold: assert property (!we_n_out && $past(!we_n_out) |->
      $stable(addr_out) && $stable(dq_o_out)) else $error("addr moved");
   a_write_drive: assert property (!we_n_out |-> dq_oe_out &&
      !ce_n_out && oe_n_out) else $error("write pins");
   a_no_take_write: assert property (!we_n_out |->
      !cmd_ready_out) else $error("ready in write");
   a_pin_reset: assert property ($rose(hw_reset_in) |-> ##[0:2]
      !reset_n_out) else $error("no pin reset");
   a_reset_hold: assert property ($fell(reset_n_out) |=>
      !reset_n_out [*8]) else $error("reset short");
   a_done_ready: assert property (done_out |-> ready_busy_n &&
      $past(ready_busy_n, 2)) else $error("done early");
   a_done_idle: assert property (done_out && !cmd_valid_in |=>
      !busy_out) else $error("busy after done");
   c_done: cover property (done_out);
   c_susp: cover property ($rose(suspended_out));
   c_pin: cover property ($fell(reset_n_out));
endmodule : fec_ctrl_chk
bind fec_ctrl fec_ctrl_chk #(.TOUT_CYC(TOUT_CYC), .SUSP_CYC(SUSP_CYC))
   fec_ctrl_chk_inst (.clk_in(clk_in), .rst_in(rst_in),
   .cmd_valid_in(cmd_valid_in), .cmd_op_in(cmd_op_in),
   .hw_reset_in(hw_reset_in), .cmd_ready_out(cmd_ready_out),
   .busy_out(busy_out), .suspended_out(suspended_out), .done_out(done_out),
   .we_n_out(we_n_out), .ce_n_out(ce_n_out), .oe_n_out(oe_n_out),
   .reset_n_out(reset_n_out), .addr_out(addr_out), .dq_o_out(dq_o_out),
   .dq_oe_out(dq_oe_out), .ready_busy_n(ready_busy_n));

// *** tb/fec_flash_model.sv ***
// behavioural nor flash erase command logic
// assumes strobes sampled on the controller clock
`timescale 1ns/1ps
module fec_flash_model
   import fec_pkg::*;
#(
   parameter int unsigned LOAD  = 20,
   parameter int unsigned ERASE = 60
)(
   input  wire logic        clk_in,       // sampling clock
   input  wire logic        rst_in,       // power-up reset
   input  wire logic        we_n,         // write strobe
   input  wire logic        ce_n,         // chip enable
   input  wire logic        oe_n,         // output enable
   input  wire logic        reset_n,      // reset pin
   input  wire logic [11:0] addr,         // address
   input  wire logic [7:0]  dq,           // write data
   output logic      [7:0]  dq_out,       // status data
   output logic             ready_busy_n  // ready pin
);
   logic [19:0] seq [5];
   logic        we_q, run, susp, chip;
   logic [2:0]  idx;
   int unsigned load, left;
   wire rise = !we_q && we_n && !ce_n && oe_n;
   wire ok = (idx < 3'h5) && ({addr, dq} == seq[idx]);
   wire act = run && !susp;
   assign seq = '{{UNLOCK_A1, UNLOCK_D1}, {UNLOCK_A2, UNLOCK_D2},
      {UNLOCK_A1, CMD_SETUP}, {UNLOCK_A1, UNLOCK_D1}, {UNLOCK_A2, UNLOCK_D2}};
   assign ready_busy_n = !act;
   assign dq_out = {!act, 3'h0, run && load == 0, 3'h0};
   always_ff @(posedge clk_in or posedge rst_in or negedge reset_n) begin
      if (rst_in || !reset_n) begin
         {idx, run, susp, chip, load, left} <= '0;
         we_q <= 1'b1;
      end else begin
         we_q <= we_n;
         if (load > 0 && !susp) load <= load - 1;
         else if (act && left > 0) left <= left - 1;
         else if (act) run <= 1'b0;
         if (rise) begin
            if (run && susp) begin
               if (dq == CMD_RESUME) susp <= 1'b0;
            end else if (run) begin
               if (load > 0 && dq == CMD_SECTOR) load <= LOAD;
               else if (!chip && dq == CMD_SUSPEND) begin
                  susp <= 1'b1;
                  load <= 0;
               end else if (load > 0) run <= 1'b0;
            end else if (idx == 3'h5) begin
               idx  <= '0;
               chip <= dq == CMD_CHIP;
               run  <= dq == CMD_CHIP || dq == CMD_SECTOR;
               load <= dq == CMD_SECTOR ? LOAD : 0;
               left <= ERASE;
            end else idx <= ok ? idx + 3'h1 : '0;
         end
      end
   end
endmodule : fec_flash_model

// *** tb/flash_erase_command_control_test.sv ***
// testbench for the erase controller with a flash model
// assumes short load and suspend counts
`timescale 1ns/1ps
module flash_erase_command_control_test;
   import fec_pkg::*;
   logic clk_in, rst_in, cmd_valid_in, hw_reset_in, cmd_ready_out;
   logic busy_out, suspended_out, loading_out, done_out, we_n_out;
   logic ce_n_out, oe_n_out, reset_n_out, dq_oe_out, ready_busy_n;
   logic [2:0]  cmd_op_in;
   logic [11:0] cmd_sector_in, addr_out;
   logic [7:0]  dq_o_out, dq_i_in;
   logic [19:0] wq[$];
   int error_cnt, checks, i;
   fec_ctrl #(.TOUT_CYC(20), .SUSP_CYC(20)) fec_ctrl_inst (.*);
   fec_flash_model fec_flash_model_inst (.clk_in(clk_in), .rst_in(rst_in),
      .we_n(we_n_out), .ce_n(ce_n_out), .oe_n(oe_n_out),
      .reset_n(reset_n_out), .addr(addr_out), .dq(dq_o_out), .dq_out(dq_i_in),
      .ready_busy_n(ready_busy_n));
   always @(posedge we_n_out) if (!rst_in) wq.push_back({addr_out, dq_o_out});
   initial begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end
   // ---------------------------------------------
   // tasks
   // ---------------------------------------------
   task automatic check(input logic [19:0] seen, input logic [19:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic await(ref logic s, input int lim);
      int n;
      n = 0;
      @(negedge clk_in);
      while (s !== 1'b1 && n < lim) begin
         @(negedge clk_in);
         n++;
      end
      check(20'(n < lim), 20'h1);
   endtask : await
   task automatic send(input logic [2:0] op, input logic [11:0] sec);
      @(negedge clk_in);
      await(cmd_ready_out, 200);
      @(posedge clk_in);
      cmd_valid_in <= 1'b1;
      cmd_op_in <= op;
      cmd_sector_in <= sec;
      @(posedge clk_in);
      cmd_valid_in <= 1'b0;
   endtask : send
   task automatic results();
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : results
   initial begin
      #(20000 * 100);
      error_cnt++;
      results();
   end
   // ---------------------------------------------
   // tests
   // ---------------------------------------------
   initial begin
      {cmd_valid_in, cmd_op_in, cmd_sector_in, hw_reset_in} = '0;
      rst_in = 1'b1;
      repeat (8) @(posedge clk_in);
      rst_in <= 1'b0;
      send(OP_CHIP, 12'h000);
      send(OP_SUSPEND, 12'h000);
      await(done_out, 3000);
      check(20'(wq.size()), 20'd6);
      for (i = 0; i < 5; i++) check(wq[i], fec_flash_model_inst.seq[i]);
      check(wq[5], {UNLOCK_A1, CMD_CHIP});
      check(20'(busy_out), 20'h0);
      wq.delete();
      send(OP_SECTOR, 12'h100);
      send(OP_ADD_SECTOR, 12'h200);
      send(OP_SUSPEND, 12'h000);
      await(suspended_out, 300);
      await(cmd_ready_out, 20);
      check(wq[5], {12'h100, CMD_SECTOR});
      check(wq[6], {12'h200, CMD_SECTOR});
      check(20'(wq[7][7:0]), 20'(CMD_SUSPEND));
      send(OP_RESUME, 12'h000);
      send(OP_RESUME, 12'h000);
      send(OP_SUSPEND, 12'h000);
      await(suspended_out, 300);
      send(OP_RESUME, 12'h000);
      await(done_out, 3000);
      check(20'(wq.size()), 20'd11);
      check(20'(wq[8][7:0]), 20'(CMD_RESUME));
      wq.delete();
      send(OP_SECTOR, 12'h300);
      await(loading_out, 100);
      send(OP_RESET, 12'h000);
      repeat (10) @(negedge clk_in);
      check(20'(wq[6][7:0]), 20'(CMD_RESET));
      check(20'(busy_out), 20'h0);
      send(OP_SECTOR, 12'h400);
      repeat (40) @(posedge clk_in);
      hw_reset_in <= 1'b1;
      @(posedge clk_in);
      hw_reset_in <= 1'b0;
      repeat (3) @(negedge clk_in);
      check(20'(reset_n_out), 20'h0);
      repeat (20) @(negedge clk_in);
      check(20'({busy_out, ready_busy_n}), 20'h1);
      results();
   end
endmodule : flash_erase_command_control_test
